// ---- logic/ict_pkg.sv ----
// Package of timing constants and encodings for the instruction cycle timer
package ict_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned OP_W = 5;
    localparam int unsigned N_W = 3;
    // Operation classes
    typedef enum logic [4:0] {
        OP_WORD_ADD = 5'h00,
        OP_WORD_SUBTRACT = 5'h01,
        OP_WORD_COMPARE = 5'h02,
        OP_UNSIGNED_MULTIPLY = 5'h03,
        OP_UNSIGNED_DIVIDE = 5'h04,
        OP_BYTE_INCDEC = 5'h05,
        OP_PAIR_INCDEC = 5'h06,
        OP_BYTE_SHIFT = 5'h07,
        OP_PAIR_SHIFT = 5'h08,
        OP_NIBBLE_ROTATE_RIGHT = 5'h09,
        OP_NIBBLE_ROTATE_LEFT = 5'h0A,
        OP_DECIMAL_ADJUST = 5'h0B,
        OP_CARRY_FLAG_OP = 5'h0C,
        OP_BIT_SAVE = 5'h0D,
        OP_SUBROUTINE_RETURN = 5'h0E,
        OP_SP_LOAD_IMM = 5'h0F,
        OP_SP_INCDEC = 5'h10,
        OP_BRANCH_IF_CARRY = 5'h11
    } ict_op_type;
    // Memory areas
    typedef enum logic [1:0] {
        AREA_DUAL_PORT_RAM = 2'h0,
        AREA_OTHER_INTERNAL_RAM = 2'h1,
        AREA_SFR = 2'h2,
        AREA_EXTERNAL_MEMORY = 2'h3
    } ict_area_type;
    // Fast fetch cycle counts
    localparam logic [7:0] F_WORD_ADD = 8'h04;
    localparam logic [7:0] F_WORD_CMP = 8'h03;
    localparam logic [7:0] F_MUL = 8'h16;
    localparam logic [7:0] F_DIV = 8'h4A;
    localparam logic [7:0] F_BYTE_INCDEC = 8'h02;
    localparam logic [7:0] F_SHIFT_BASE = 8'h03;
    localparam logic [7:0] F_NRR_DUAL_PORT_RAM_AREA = 8'h18;
    localparam logic [7:0] F_NRR_OTHER = 8'h20;
    localparam logic [7:0] F_NRL_DUAL_PORT_RAM_AREA = 8'h19;
    localparam logic [7:0] F_NRL_OTHER = 8'h21;
    localparam logic [7:0] F_CARRY_OP = 8'h02;
    localparam logic [7:0] F_BIT_SAVE_DUAL_PORT_RAM_AREA = 8'h03;
    localparam logic [7:0] F_BIT_SAVE_OTHER = 8'h07;
    localparam logic [7:0] F_SP_LOAD = 8'h08;
    localparam logic [7:0] F_SP_INCDEC = 8'h05;
    localparam logic [7:0] F_BR_NOT = 8'h02;
    localparam logic [7:0] F_BR_INT = 8'h04;
    localparam logic [7:0] F_BR_EXT = 8'h06;
    // External fetch cycle counts
    localparam logic [7:0] X_WORD_ADD = 8'h09;
    localparam logic [7:0] X_WORD_CMP = 8'h09;
    localparam logic [7:0] X_MUL = 8'h18;
    localparam logic [7:0] X_DIV = 8'h4C;
    localparam logic [7:0] X_BYTE_INCDEC = 8'h03;
    localparam logic [7:0] X_SHIFT_BASE = 8'h05;
    localparam logic [7:0] X_NRR_DUAL_PORT_RAM_AREA = 8'h1A;
    localparam logic [7:0] X_NRR_OTHER = 8'h22;
    localparam logic [7:0] X_NRL_DUAL_PORT_RAM_AREA = 8'h1B;
    localparam logic [7:0] X_NRL_OTHER = 8'h23;
    localparam logic [7:0] X_CARRY_OP = 8'h03;
    localparam logic [7:0] X_BIT_SAVE_DUAL_PORT_RAM_AREA = 8'h06;
    localparam logic [7:0] X_BIT_SAVE_OTHER = 8'h0B;
    localparam logic [7:0] X_SP_LOAD = 8'h0C;
    localparam logic [7:0] X_SP_INCDEC = 8'h07;
    localparam logic [7:0] X_BR_NOT = 8'h06;
    localparam logic [7:0] X_BR_INT = 8'h07;
    localparam logic [7:0] X_BR_EXT = 8'h09;
    // Common counts
    localparam logic [7:0] PAIR_INCDEC = 8'h03;
    localparam logic [7:0] DEC_ADJUST = 8'h03;
    localparam logic [7:0] RET_DUAL_PORT_RAM_AREA = 8'h0A;
    localparam logic [7:0] RET_OTHER = 8'h0E;
    localparam logic [7:0] SHIFT_BYTE_STEP = 8'h02;
    localparam logic [7:0] SHIFT_PAIR_STEP = 8'h03;
    localparam logic [7:0] ONE = 8'h01;
endpackage

// ---- logic/ict_cycle_lut.sv ----
// Cycle count lookup per operation, fetch mode and area
`timescale 1ns/1ps
`default_nettype none
module ict_cycle_lut
(
    // Request
    input wire ict_pkg::ict_op_type op,
    input wire logic fast,
    input wire ict_pkg::ict_area_type area,
    input wire logic [ict_pkg::N_W-1:0] shift_n,
    input wire logic taken,
    input wire logic target_ext,
    input wire logic align_odd,
    // Result
    output logic [ict_pkg::CNT_W-1:0] cycles,
    output logic illegal
);
    logic [7:0] n8;
    logic dual_port_ram_area;
    assign n8 = {5'h00, shift_n};
    assign dual_port_ram_area = (area == ict_pkg::AREA_DUAL_PORT_RAM);
    always_comb
    begin
        cycles = ict_pkg::ONE;
        illegal = 1'b0;
        case (op)
            ict_pkg::OP_WORD_ADD, ict_pkg::OP_WORD_SUBTRACT:
                cycles = fast ? ict_pkg::F_WORD_ADD : ict_pkg::X_WORD_ADD;
            ict_pkg::OP_WORD_COMPARE:
                cycles = fast ? ict_pkg::F_WORD_CMP : ict_pkg::X_WORD_CMP;
            ict_pkg::OP_UNSIGNED_MULTIPLY:
                cycles = fast ? ict_pkg::F_MUL : ict_pkg::X_MUL;
            ict_pkg::OP_UNSIGNED_DIVIDE:
                cycles = fast ? ict_pkg::F_DIV : ict_pkg::X_DIV;
            ict_pkg::OP_BYTE_INCDEC:
                cycles = fast ? ict_pkg::F_BYTE_INCDEC : ict_pkg::X_BYTE_INCDEC;
            ict_pkg::OP_PAIR_INCDEC:
                cycles = ict_pkg::PAIR_INCDEC;
            ict_pkg::OP_BYTE_SHIFT:
                cycles = 8'((fast ? ict_pkg::F_SHIFT_BASE : ict_pkg::X_SHIFT_BASE)
                    + ict_pkg::SHIFT_BYTE_STEP * n8);
            ict_pkg::OP_PAIR_SHIFT:
                cycles = 8'((fast ? ict_pkg::F_SHIFT_BASE : ict_pkg::X_SHIFT_BASE)
                    + ict_pkg::SHIFT_PAIR_STEP * n8);
            ict_pkg::OP_NIBBLE_ROTATE_RIGHT:
                if (fast)
                    cycles = dual_port_ram_area ? ict_pkg::F_NRR_DUAL_PORT_RAM_AREA : ict_pkg::F_NRR_OTHER;
                else
                    cycles = dual_port_ram_area ? ict_pkg::X_NRR_DUAL_PORT_RAM_AREA : ict_pkg::X_NRR_OTHER;
            ict_pkg::OP_NIBBLE_ROTATE_LEFT:
                if (fast)
                    cycles = dual_port_ram_area ? ict_pkg::F_NRL_DUAL_PORT_RAM_AREA : ict_pkg::F_NRL_OTHER;
                else
                    cycles = dual_port_ram_area ? ict_pkg::X_NRL_DUAL_PORT_RAM_AREA : ict_pkg::X_NRL_OTHER;
            ict_pkg::OP_DECIMAL_ADJUST:
                cycles = ict_pkg::DEC_ADJUST;
            ict_pkg::OP_CARRY_FLAG_OP:
                cycles = fast ? ict_pkg::F_CARRY_OP : ict_pkg::X_CARRY_OP;
            ict_pkg::OP_BIT_SAVE:
                if (fast)
                    cycles = dual_port_ram_area ? ict_pkg::F_BIT_SAVE_DUAL_PORT_RAM_AREA : ict_pkg::F_BIT_SAVE_OTHER;
                else
                    cycles = dual_port_ram_area ? ict_pkg::X_BIT_SAVE_DUAL_PORT_RAM_AREA : ict_pkg::X_BIT_SAVE_OTHER;
            ict_pkg::OP_SUBROUTINE_RETURN:
                // Slash pair picked by stack alignment
                cycles = 8'((dual_port_ram_area ? ict_pkg::RET_DUAL_PORT_RAM_AREA : ict_pkg::RET_OTHER)
                    + {7'h00, align_odd});
            ict_pkg::OP_SP_LOAD_IMM:
                cycles = fast ? ict_pkg::F_SP_LOAD : ict_pkg::X_SP_LOAD;
            ict_pkg::OP_SP_INCDEC:
                cycles = fast ? ict_pkg::F_SP_INCDEC : ict_pkg::X_SP_INCDEC;
            ict_pkg::OP_BRANCH_IF_CARRY:
                if (!taken)
                    cycles = fast ? ict_pkg::F_BR_NOT : ict_pkg::X_BR_NOT;
                else if (target_ext)
                    cycles = fast ? ict_pkg::F_BR_EXT : ict_pkg::X_BR_EXT;
                else
                    cycles = fast ? ict_pkg::F_BR_INT : ict_pkg::X_BR_INT;
            default:
                illegal = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

// ---- logic/ict_sync.sv ----
// Two-flop synchroniser for the fast-fetch level
`timescale 1ns/1ps
`default_nettype none
module ict_sync
(
    // Clock
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Level
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else if (ce)
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q;
endmodule
`default_nettype wire

// ---- logic/ict_timer.sv ----
// Instruction cycle timer top
`timescale 1ns/1ps
`default_nettype none
module ict_timer
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Fetch mode and EEPROM area pins
    input wire logic fast_fetch_select,
    input wire logic fetch_from_internal_rom,
    input wire logic eeprom_area,
    // Instruction issue
    input wire logic issue,
    input wire ict_pkg::ict_op_type op,
    input wire ict_pkg::ict_area_type area,
    input wire logic [ict_pkg::N_W-1:0] shift_n,
    input wire logic taken,
    input wire logic target_ext,
    input wire logic stack_odd,
    // Status
    output logic busy,
    output logic done,
    output logic fault,
    output logic [ict_pkg::CNT_W-1:0] last_cycles
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } ict_state_type;

    ict_state_type state_q;
    logic fast_sync;
    logic fast_eff;
    logic [ict_pkg::CNT_W-1:0] lut_cycles;
    logic lut_illegal;
    logic bad_area;
    logic [ict_pkg::CNT_W-1:0] remain_q;
    logic [ict_pkg::CNT_W-1:0] elapsed_q;
    logic accept;

    ict_sync u_sync
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .din(fast_fetch_select),
        .dout(fast_sync)
    );

    // Internal ROM with select clear falls back to external counts
    assign fast_eff = fast_sync & fetch_from_internal_rom;

    ict_cycle_lut u_lut
    (
        .op(op),
        .fast(fast_eff),
        .area(area),
        .shift_n(shift_n),
        .taken(taken),
        .target_ext(target_ext),
        .align_odd(stack_odd),
        .cycles(lut_cycles),
        .illegal(lut_illegal)
    );

    // Nibble rotates refused on the EEPROM area
    assign bad_area = eeprom_area && (op == ict_pkg::OP_NIBBLE_ROTATE_RIGHT
        || op == ict_pkg::OP_NIBBLE_ROTATE_LEFT);
    assign accept = ce && issue && (state_q == ST_IDLE);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_q <= ST_IDLE;
        else if (ce)
        begin
            case (state_q)
                ST_IDLE:
                    if (issue && !bad_area && !lut_illegal && lut_cycles > ict_pkg::ONE)
                        state_q <= ST_RUN;
                ST_RUN:
                    if (remain_q == ict_pkg::ONE)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // One decrement per clock period with ce high
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            remain_q <= '0;
            elapsed_q <= '0;
        end
        else if (ce)
        begin
            if (accept && !bad_area && !lut_illegal)
            begin
                remain_q <= lut_cycles - ict_pkg::ONE;
                elapsed_q <= ict_pkg::ONE;
            end
            else if (state_q == ST_RUN)
            begin
                remain_q <= remain_q - ict_pkg::ONE;
                elapsed_q <= elapsed_q + ict_pkg::ONE;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            fault <= 1'b0;
            last_cycles <= '0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            fault <= 1'b0;
            if (accept && (bad_area || lut_illegal))
                fault <= 1'b1;
            else if (accept && lut_cycles == ict_pkg::ONE)
            begin
                done <= 1'b1;
                last_cycles <= lut_cycles;
            end
            else if (accept)
                busy <= 1'b1;
            else if (state_q == ST_RUN && remain_q == ict_pkg::ONE)
            begin
                busy <= 1'b0;
                done <= 1'b1;
                last_cycles <= 8'(elapsed_q + ict_pkg::ONE);
            end
        end
    end

    AST_DURATION: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(busy) |-> (state_q == ST_RUN) && (remain_q != '0))
        else $error("busy rise malformed");
    AST_DONE_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
        (done && ce) |-> last_cycles != '0)
        else $error("done with zero cycles");
    AST_NO_EEPROM_NIBBLE: assert property (@(posedge clk_sys) disable iff (rst)
        (accept && bad_area) |=> fault && !busy)
        else $error("nibble rotate on eeprom not refused");
    AST_WORD_ADD: assert property (@(posedge clk_sys) disable iff (rst)
        (op == ict_pkg::OP_WORD_ADD) |-> lut_cycles == (fast_eff ? 8'h04 : 8'h09))
        else $error("word add count wrong");
    AST_MUL: assert property (@(posedge clk_sys) disable iff (rst)
        (op == ict_pkg::OP_UNSIGNED_MULTIPLY) |-> lut_cycles == (fast_eff ? 8'h16 : 8'h18))
        else $error("multiply count wrong");
    AST_FALLBACK: assert property (@(posedge clk_sys) disable iff (rst)
        (!fast_sync && op == ict_pkg::OP_BRANCH_IF_CARRY && !taken) |-> lut_cycles == 8'h06)
        else $error("fallback count wrong");
    AST_SHIFT: assert property (@(posedge clk_sys) disable iff (rst)
        (op == ict_pkg::OP_PAIR_SHIFT && fast_eff)
        |-> lut_cycles == 8'(8'h03 + 8'h03 * {5'h00, shift_n}))
        else $error("pair shift count wrong");
    AST_RETURN: assert property (@(posedge clk_sys) disable iff (rst)
        (op == ict_pkg::OP_SUBROUTINE_RETURN && area == ict_pkg::AREA_DUAL_PORT_RAM)
        |-> lut_cycles == (stack_odd ? 8'h0B : 8'h0A))
        else $error("return count wrong");
    AST_DECIMAL: assert property (@(posedge clk_sys) disable iff (rst)
        (op == ict_pkg::OP_DECIMAL_ADJUST) |-> lut_cycles == 8'h03)
        else $error("decimal adjust count wrong");
    AST_END: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && state_q == ST_RUN && remain_q == ict_pkg::ONE) |=> done && !busy)
        else $error("run end missed");
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the instruction cycle timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys;
    logic rst;
    logic ce;
    logic sel;
    logic rom;
    logic eep;
    logic issue;
    ict_pkg::ict_op_type op;
    ict_pkg::ict_area_type area;
    logic [2:0] shift_n;
    logic taken;
    logic target_ext;
    logic stack_odd;
    logic busy;
    logic done;
    logic fault;
    logic [7:0] last_cycles;
    int fail_count = 0;
    int n_checks = 0;

    ict_timer u_dut
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .fast_fetch_select(sel),
        .fetch_from_internal_rom(rom),
        .eeprom_area(eep),
        .issue(issue),
        .op(op),
        .area(area),
        .shift_n(shift_n),
        .taken(taken),
        .target_ext(target_ext),
        .stack_odd(stack_odd),
        .busy(busy),
        .done(done),
        .fault(fault),
        .last_cycles(last_cycles)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Synchroniser needs two edges before the new level counts
    task automatic set_mode(input logic s, input logic r);
        @(posedge clk_sys);
        sel <= s;
        rom <= r;
        repeat (3) @(posedge clk_sys);
    endtask

    // flg packs taken, target_ext, stack_odd
    task automatic run_op(input ict_pkg::ict_op_type o, input ict_pkg::ict_area_type a,
        input logic [2:0] n, input logic [2:0] flg, input logic [7:0] exp);
        int cnt;
        cnt = 0;
        @(posedge clk_sys);
        issue <= 1'b1;
        op <= o;
        area <= a;
        shift_n <= n;
        {taken, target_ext, stack_odd} <= flg;
        @(posedge clk_sys);
        issue <= 1'b0;
        // Take edge counts as cycle one; done is seen after edge N
        #1;
        cnt = 1;
        check("fault", 8'h00, {7'h00, fault});
        if (exp > 8'h01)
            check("busy", 8'h01, {7'h00, busy});
        while (done !== 1'b1 && cnt < 200)
        begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
        check("duration", exp, cnt[7:0]);
        check("last_cycles", exp, last_cycles);
    endtask

    task automatic t_word();
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m[0], 1'b1);
            run_op(ict_pkg::OP_WORD_ADD, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 4 : 9);
            run_op(ict_pkg::OP_WORD_SUBTRACT, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 4 : 9);
            run_op(ict_pkg::OP_WORD_COMPARE, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 3 : 9);
            run_op(ict_pkg::OP_UNSIGNED_MULTIPLY, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 22 : 24);
            run_op(ict_pkg::OP_UNSIGNED_DIVIDE, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 74 : 76);
        end
        $display("Test word arithmetic done");
    endtask

    task automatic t_simple();
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m[0], 1'b1);
            run_op(ict_pkg::OP_BYTE_INCDEC, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 2 : 3);
            run_op(ict_pkg::OP_PAIR_INCDEC, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, 3);
            run_op(ict_pkg::OP_DECIMAL_ADJUST, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, 3);
            run_op(ict_pkg::OP_CARRY_FLAG_OP, ict_pkg::AREA_SFR, 3'h0, 3'h0, m ? 2 : 3);
            run_op(ict_pkg::OP_SP_LOAD_IMM, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 8 : 12);
            run_op(ict_pkg::OP_SP_INCDEC, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 5 : 7);
        end
        $display("Test simple counts done");
    endtask

    task automatic t_shift();
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m[0], 1'b1);
            for (int n = 1; n < 8; n++)
            begin
                run_op(ict_pkg::OP_BYTE_SHIFT, ict_pkg::AREA_DUAL_PORT_RAM, n[2:0], 3'h0, (m ? 3 : 5) + 2 * n);
                run_op(ict_pkg::OP_PAIR_SHIFT, ict_pkg::AREA_DUAL_PORT_RAM, n[2:0], 3'h0, (m ? 3 : 5) + 3 * n);
            end
        end
        $display("Test shifts done");
    endtask

    task automatic t_nibble();
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m[0], 1'b1);
            run_op(ict_pkg::OP_NIBBLE_ROTATE_RIGHT, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 24 : 26);
            run_op(ict_pkg::OP_NIBBLE_ROTATE_RIGHT, ict_pkg::AREA_EXTERNAL_MEMORY, 3'h0, 3'h0, m ? 32 : 34);
            run_op(ict_pkg::OP_NIBBLE_ROTATE_LEFT, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 25 : 27);
            run_op(ict_pkg::OP_NIBBLE_ROTATE_LEFT, ict_pkg::AREA_OTHER_INTERNAL_RAM, 3'h0, 3'h0, m ? 33 : 35);
        end
        // EEPROM operand must be refused
        @(posedge clk_sys);
        issue <= 1'b1;
        op <= ict_pkg::OP_NIBBLE_ROTATE_LEFT;
        eep <= 1'b1;
        @(posedge clk_sys);
        issue <= 1'b0;
        #1;
        check("fault", 8'h01, {7'h00, fault});
        check("done", 8'h00, {7'h00, done});
        @(posedge clk_sys);
        eep <= 1'b0;
        $display("Test nibble rotates done");
    endtask

    task automatic t_ret_branch();
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m[0], 1'b1);
            run_op(ict_pkg::OP_SUBROUTINE_RETURN, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, 10);
            run_op(ict_pkg::OP_SUBROUTINE_RETURN, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h1, 11);
            run_op(ict_pkg::OP_SUBROUTINE_RETURN, ict_pkg::AREA_OTHER_INTERNAL_RAM, 3'h0, 3'h0, 14);
            run_op(ict_pkg::OP_SUBROUTINE_RETURN, ict_pkg::AREA_EXTERNAL_MEMORY, 3'h0, 3'h1, 15);
            run_op(ict_pkg::OP_BRANCH_IF_CARRY, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, m ? 2 : 6);
            run_op(ict_pkg::OP_BRANCH_IF_CARRY, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h4, m ? 4 : 7);
            run_op(ict_pkg::OP_BRANCH_IF_CARRY, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h6, m ? 6 : 9);
        end
        $display("Test return and branch done");
    endtask

    task automatic t_mode();
        // Fast select without internal ROM fetch keeps external counts
        set_mode(1'b1, 1'b0);
        run_op(ict_pkg::OP_WORD_ADD, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, 9);
        set_mode(1'b0, 1'b1);
        run_op(ict_pkg::OP_SP_LOAD_IMM, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, 12);
        set_mode(1'b1, 1'b1);
        run_op(ict_pkg::OP_SP_LOAD_IMM, ict_pkg::AREA_DUAL_PORT_RAM, 3'h0, 3'h0, 8);
        // Issue with clock enable low must not be taken
        @(posedge clk_sys);
        ce <= 1'b0;
        issue <= 1'b1;
        op <= ict_pkg::OP_WORD_ADD;
        @(posedge clk_sys);
        issue <= 1'b0;
        #1;
        check("frozen busy", 8'h00, {7'h00, busy});
        check("frozen done", 8'h00, {7'h00, done});
        @(posedge clk_sys);
        ce <= 1'b1;
        $display("Test fetch mode done");
    endtask

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        sel = 1'b0;
        rom = 1'b1;
        eep = 1'b0;
        issue = 1'b0;
        op = ict_pkg::OP_WORD_ADD;
        area = ict_pkg::AREA_DUAL_PORT_RAM;
        shift_n = 3'h0;
        taken = 1'b0;
        target_ext = 1'b0;
        stack_odd = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_word();
        t_simple();
        t_shift();
        t_nibble();
        t_ret_branch();
        t_mode();
        test_done();
    end

    // Whole run is about 1200 cycles
    initial
    begin
        #100000;
        fail_count++;
        $display("Error watchdog expected 0 seen 1");
        test_done();
    end
endmodule
`default_nettype wire
